// file: pcmb_pkg.sv
package pcmb_pkg;

   // Bus geometry: byte address = {core, upper half, index, 2'b00}.
   localparam int ADDR_W   = 12;
   localparam int IDX_LSB  = 2;
   localparam int IDX_W    = 8;
   localparam int HI_BIT   = 10;
   localparam int CORE_BIT = 11;

   // Register indices as printed; the byte address is four times these.
   localparam logic [7:0] IDX_MC_ADDR  = 8'h00;
   localparam logic [7:0] IDX_MC_TYPE  = 8'h01;
   localparam logic [7:0] IDX_FILTER   = 8'h06;
   localparam logic [7:0] IDX_STAMP    = 8'h10;
   localparam logic [7:0] IDX_PLATFORM = 8'h17;
   localparam logic [7:0] IDX_INTC     = 8'h1B;
   localparam logic [7:0] IDX_CFG      = 8'h2A;

   // Platform identification field.
   localparam int PLAT_LSB = 50;
   localparam int PLAT_W   = 3;

   // Power-on configuration field positions.
   localparam int CFG_W         = 13;
   localparam int CFG_DATA_CHK  = 1;
   localparam int CFG_RESP_CHK  = 2;
   localparam int CFG_APAR_DRV  = 3;
   localparam int CFG_BUS_ERR_N_REQ  = 4;
   localparam int CFG_BUS_ERR_N_INT  = 6;
   localparam int CFG_REINIT_DRV = 7;
   localparam int CFG_TRISTATE  = 8;
   localparam int CFG_SELF_TEST = 9;
   localparam int CFG_APAR_OBS  = 10;
   localparam int CFG_REINIT_OBS = 12;
   localparam logic [12:0] CFG_RW_MASK = 13'h00DE;
   localparam logic [12:0] CFG_RST     = 13'h0000;

   // Reset value of the per-core writable registers.
   localparam logic [63:0] REG_RST = 64'h0000000000000000;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Merges a 32-bit write with byte strobes into one half of a register.
   function automatic logic [63:0] pcmb_merge(input logic [63:0] old,
                                              input logic        hi,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
      logic [63:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[(hi ? 32 : 0) + 8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : pcmb_merge

   // Picks the half of a register that one bus word shows.
   function automatic logic [31:0] pcmb_half(input logic [63:0] v,
                                             input logic        hi);
      return hi ? v[63:32] : v[31:0];
   endfunction : pcmb_half

   // True for indices that each core holds a copy of.
   function automatic logic pcmb_is_core(input logic [7:0] idx);
      return idx == IDX_MC_ADDR || idx == IDX_MC_TYPE ||
             idx == IDX_FILTER  || idx == IDX_STAMP ||
             idx == IDX_INTC;
   endfunction : pcmb_is_core

   // True for indices held once for both cores.
   function automatic logic pcmb_is_shared(input logic [7:0] idx);
      return idx == IDX_PLATFORM || idx == IDX_CFG;
   endfunction : pcmb_is_shared

endpackage : pcmb_pkg

// file: pcmb_core_regs.sv
`timescale 1ns/10ps
module pcmb_core_regs (
   input  wire logic        clk,      // Core clock.
   input  wire logic        rst_n,    // Asynchronous reset, active low.
   input  wire logic        wr_en,    // Write strobe for this core.
   input  wire logic [7:0]  wr_idx,   // Register index written.
   input  wire logic        wr_hi,    // Upper half written.
   input  wire logic [31:0] wr_data,  // Write data.
   input  wire logic [3:0]  wr_strb,  // Byte strobes.
   input  wire logic [7:0]  rd_idx,   // Register index read.
   input  wire logic        rd_hi,    // Upper half read.
   input  wire logic [63:0] mc_addr,  // Machine check address source.
   input  wire logic [63:0] mc_type,  // Machine check type source.
   output logic      [31:0] rd_data   // Read word.
);

   logic [63:0] filter_q;
   logic [63:0] stamp_q;
   logic [63:0] intc_q;

   // Write decode for the writable copies of this core.
   wire hit_filter = wr_en && wr_idx == pcmb_pkg::IDX_FILTER;
   wire hit_stamp  = wr_en && wr_idx == pcmb_pkg::IDX_STAMP;
   wire hit_intc   = wr_en && wr_idx == pcmb_pkg::IDX_INTC;

   // Only this core's own strobe writes its copies; the stamp also counts on its own.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filter_q <= pcmb_pkg::REG_RST;
         stamp_q  <= pcmb_pkg::REG_RST;
         intc_q   <= pcmb_pkg::REG_RST;
      end else begin
         if (hit_filter) begin
            filter_q <= pcmb_pkg::pcmb_merge(filter_q, wr_hi, wr_data,
                                             wr_strb);
         end
         if (hit_intc) begin
            intc_q <= pcmb_pkg::pcmb_merge(intc_q, wr_hi, wr_data,
                                           wr_strb);
         end
         // The stamp counts every cycle; a write takes precedence.
         stamp_q <= hit_stamp ?
                    pcmb_pkg::pcmb_merge(stamp_q, wr_hi, wr_data, wr_strb) :
                    stamp_q + 64'h1;
      end
   end

   // Read selection for this core.
   wire [63:0] rd_full =
      rd_idx == pcmb_pkg::IDX_MC_ADDR ? mc_addr  :
      rd_idx == pcmb_pkg::IDX_MC_TYPE ? mc_type  :
      rd_idx == pcmb_pkg::IDX_FILTER  ? filter_q :
      rd_idx == pcmb_pkg::IDX_STAMP   ? stamp_q  :
      rd_idx == pcmb_pkg::IDX_INTC    ? intc_q   : 64'h0;
   assign rd_data = pcmb_pkg::pcmb_half(rd_full, rd_hi);

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   own_copy_a: assert property (
      !hit_filter && !hit_intc |=> $stable(filter_q) && $stable(intc_q))
      else $error("Core copy changed without its own write.");

endmodule : pcmb_core_regs

// file: pcmb_bank.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module pcmb_bank #(
   parameter int NCORES = 2  // Number of cores with private copies.
) (
   input  wire logic              clk,        // Core clock, 125 MHz.
   input  wire logic              rst_n,      // Async reset, active low.
   input  wire logic [11:0]       awaddr,     // Write address.
   input  wire logic [2:0]        awprot,     // Write protection, unused.
   input  wire logic              awvalid,    // Write address valid.
   output logic                   awready,    // Write address ready.
   input  wire logic [31:0]       wdata,      // Write data.
   input  wire logic [3:0]        wstrb,      // Write byte strobes.
   input  wire logic              wvalid,     // Write data valid.
   output logic                   wready,     // Write data ready.
   output logic [1:0]             bresp,      // Write response.
   output logic                   bvalid,     // Write response valid.
   input  wire logic              bready,     // Write response ready.
   input  wire logic [11:0]       araddr,     // Read address.
   input  wire logic [2:0]        arprot,     // Read protection, unused.
   input  wire logic              arvalid,    // Read address valid.
   output logic                   arready,    // Read address ready.
   output logic [31:0]            rdata,      // Read data.
   output logic [1:0]             rresp,      // Read response.
   output logic                   rvalid,     // Read data valid.
   input  wire logic              rready,     // Read data ready.
   input  wire logic [2:0]        plat_strap, // Platform code strap.
   input  wire logic              tristate_strap,   // Tri-state strap.
   input  wire logic              self_test_strap,  // Self-test strap.
   input  wire logic              apar_obs_strap,   // Parity observe strap.
   input  wire logic              reinit_obs_strap, // Reinit observe strap.
   input  wire logic [NCORES*64-1:0] mc_addr, // Machine check addresses.
   input  wire logic [NCORES*64-1:0] mc_type, // Machine check types.
   output logic                   data_chk_en,   // Data error checking.
   output logic                   resp_chk_en,   // Response checking.
   output logic                   apar_drv_en,   // Drive parity error.
   output logic                   bus_err_n_req_en,   // Bus error, requests.
   output logic                   bus_err_n_int_en,   // Bus error, internal.
   output logic                   reinit_drv_en  // Drive reinit error.
);

   if (NCORES < 1 || NCORES > 2) begin : g_bad_cores
      $error("NCORES must be 1 or 2.");
   end

   logic                awready_q;
   logic                wready_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                arready_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;
   logic                aw_have_q;
   logic                w_have_q;
   logic [11:0]         waddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic [12:0]         cfg_rw_q;
   logic [2:0]          plat_q;
   logic                tristate_q;
   logic                self_test_q;
   logic                apar_obs_q;
   logic                reinit_obs_q;
   logic                strap_done_q;
   logic [31:0]         core_rd [NCORES];

   // Bus outputs straight from their flip-flops.
   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Handshakes and the write that fires once address and data are held.
   wire aw_take = awvalid && awready_q;
   wire w_take  = wvalid && wready_q;
   wire ar_take = arvalid && arready_q;
   wire do_wr   = aw_have_q && w_have_q && !bvalid_q;
   wire aw_have_d = (aw_have_q || aw_take) && !do_wr;
   wire w_have_d  = (w_have_q || w_take) && !do_wr;
   wire bvalid_d  = do_wr || (bvalid_q && !bready);
   wire rvalid_d  = ar_take || (rvalid_q && !rready);

   // Write address decode.
   wire [7:0] wr_idx  = waddr_q[pcmb_pkg::IDX_LSB +: pcmb_pkg::IDX_W];
   wire       wr_hi   = waddr_q[pcmb_pkg::HI_BIT];
   wire       wr_core = waddr_q[pcmb_pkg::CORE_BIT];
   wire       wr_cfg  = wr_idx == pcmb_pkg::IDX_CFG;
   wire       wr_ok   = 32'(wr_core) < NCORES &&
                        (pcmb_pkg::pcmb_is_core(wr_idx) ||
                         pcmb_pkg::pcmb_is_shared(wr_idx));

   // Read address decode.
   wire [7:0] rd_idx  = araddr[pcmb_pkg::IDX_LSB +: pcmb_pkg::IDX_W];
   wire       rd_hi   = araddr[pcmb_pkg::HI_BIT];
   wire       rd_core = araddr[pcmb_pkg::CORE_BIT];
   wire       rd_ok   = 32'(rd_core) < NCORES &&
                        (pcmb_pkg::pcmb_is_core(rd_idx) ||
                         pcmb_pkg::pcmb_is_shared(rd_idx));

   // Shared register images; reserved positions are constant zero.
   wire [63:0] plat_full = {{(64 - pcmb_pkg::PLAT_LSB - pcmb_pkg::PLAT_W)
                            {1'b0}}, plat_q,
                            {pcmb_pkg::PLAT_LSB{1'b0}}};
   wire [12:0] cfg_view;
   assign cfg_view = cfg_rw_q |
      (13'(tristate_q)   << pcmb_pkg::CFG_TRISTATE)  |
      (13'(self_test_q)  << pcmb_pkg::CFG_SELF_TEST) |
      (13'(apar_obs_q)   << pcmb_pkg::CFG_APAR_OBS)  |
      (13'(reinit_obs_q) << pcmb_pkg::CFG_REINIT_OBS);
   wire [63:0] cfg_full = {51'h0, cfg_view};

   // Shared entries ignore the core bit, so both cores see one copy.
   wire [31:0] rd_word =
      !rd_ok                          ? 32'h0 :
      rd_idx == pcmb_pkg::IDX_PLATFORM ?
         pcmb_pkg::pcmb_half(plat_full, rd_hi) :
      rd_idx == pcmb_pkg::IDX_CFG      ?
         pcmb_pkg::pcmb_half(cfg_full, rd_hi) :
      core_rd[rd_core];

   // Per-core copies, each written only by its own core select.
   for (genvar c = 0; c < NCORES; c++) begin : g_core
      pcmb_core_regs u_core (
         .clk     (clk),
         .rst_n   (rst_n),
         .wr_en   (do_wr && wr_ok && 32'(wr_core) == c),
         .wr_idx  (wr_idx),
         .wr_hi   (wr_hi),
         .wr_data (wdata_q),
         .wr_strb (wstrb_q),
         .rd_idx  (rd_idx),
         .rd_hi   (rd_hi),
         .mc_addr (mc_addr[c*64 +: 64]),
         .mc_type (mc_type[c*64 +: 64]),
         .rd_data (core_rd[c])
      );
   end

   // Write channel: hold address and data, answer once both are in.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= pcmb_pkg::RESP_OKAY;
         waddr_q   <= 12'h000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awready_q <= !aw_have_d && !bvalid_d;
         wready_q  <= !w_have_d && !bvalid_d;
         bvalid_q  <= bvalid_d;
         if (aw_take) begin
            waddr_q <= awaddr;
         end
         if (w_take) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_wr) begin
            bresp_q <= wr_ok ? pcmb_pkg::RESP_OKAY : pcmb_pkg::RESP_SLVERR;
         end
      end
   end

   // Read channel: one read at a time, answered the cycle after it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= pcmb_pkg::RESP_OKAY;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? pcmb_pkg::RESP_OKAY : pcmb_pkg::RESP_SLVERR;
         end
      end
   end

   // Only the writable enables take bus data; the rest is masked off.
   wire [63:0] cfg_new = pcmb_pkg::pcmb_merge(cfg_full, wr_hi, wdata_q,
                                              wstrb_q);
   wire        cfg_wr  = do_wr && wr_ok && wr_cfg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rw_q <= pcmb_pkg::CFG_RST;
      end else if (cfg_wr) begin
         cfg_rw_q <= cfg_new[12:0] & pcmb_pkg::CFG_RW_MASK;
      end
   end

   // Straps are caught once, on the first edge after reset release.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_q <= 1'b0;
         plat_q       <= 3'h0;
         tristate_q   <= 1'b0;
         self_test_q  <= 1'b0;
         apar_obs_q   <= 1'b0;
         reinit_obs_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         plat_q       <= plat_strap;
         tristate_q   <= tristate_strap;
         self_test_q  <= self_test_strap;
         apar_obs_q   <= apar_obs_strap;
         reinit_obs_q <= reinit_obs_strap;
      end
   end

   // Feature enables leave straight from the shared register.
   assign data_chk_en   = cfg_rw_q[pcmb_pkg::CFG_DATA_CHK];
   assign resp_chk_en   = cfg_rw_q[pcmb_pkg::CFG_RESP_CHK];
   assign apar_drv_en   = cfg_rw_q[pcmb_pkg::CFG_APAR_DRV];
   assign bus_err_n_req_en   = cfg_rw_q[pcmb_pkg::CFG_BUS_ERR_N_REQ];
   assign bus_err_n_int_en   = cfg_rw_q[pcmb_pkg::CFG_BUS_ERR_N_INT];
   assign reinit_drv_en = cfg_rw_q[pcmb_pkg::CFG_REINIT_DRV];

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // A write of the low configuration byte, as a one-cycle sequence.
   sequence s_cfg_low_wr;
      cfg_wr && !wr_hi && wstrb_q[0];
   endsequence
   sequence s_cfg_bit1_wr;
      cfg_wr && !wr_hi && wstrb_q[0] && wdata_q[1];
   endsequence

   data_chk_a: assert property (
      s_cfg_low_wr |=> data_chk_en == $past(wdata_q[1]))
      else $error("Data check enable did not follow its write.");

   resp_chk_a: assert property (
      s_cfg_low_wr |=> resp_chk_en == $past(wdata_q[2]))
      else $error("Response check enable did not follow its write.");

   apar_drive_a: assert property (
      s_cfg_low_wr |=> apar_drv_en == $past(wdata_q[3]))
      else $error("Parity drive enable did not follow its write.");

   bus_err_n_enables_a: assert property (
      s_cfg_low_wr |=> bus_err_n_req_en == $past(wdata_q[4]) &&
                       bus_err_n_int_en == $past(wdata_q[6]))
      else $error("Bus error enables did not follow their write.");

   reinit_drive_a: assert property (
      s_cfg_low_wr |=> reinit_drv_en == $past(wdata_q[7]))
      else $error("Reinit drive enable did not follow its write.");

   enable_hold_a: assert property (
      s_cfg_bit1_wr ##1 !cfg_wr [*2] |-> data_chk_en && $stable(bus_err_n_int_en))
      else $error("Enable changed without a write.");

   status_ro_a: assert property (
      cfg_wr |=> $stable(cfg_view[12:8]))
      else $error("Read-only status changed by a write.");

   plat_read_a: assert property (
      ar_take && rd_ok && rd_idx == pcmb_pkg::IDX_PLATFORM && rd_hi
      |=> rdata_q == {11'h0, plat_q, 18'h0} && rvalid_q)
      else $error("Platform word wrong.");

   cfg_read_a: assert property (
      ar_take && rd_ok && rd_idx == pcmb_pkg::IDX_CFG && !rd_hi
      |=> rdata_q[0] == 1'b0 && rdata_q[5] == 1'b0 && rdata_q[11] == 1'b0
          && rdata_q[8] == tristate_q && rdata_q[9] == self_test_q)
      else $error("Configuration word wrong.");

   obs_read_a: assert property (
      ar_take && rd_ok && rd_idx == pcmb_pkg::IDX_CFG && !rd_hi
      |=> rdata_q[10] == apar_obs_q && rdata_q[12] == reinit_obs_q)
      else $error("Observation status wrong.");

   shared_one_a: assert property (
      ar_take && rd_ok && rd_idx == pcmb_pkg::IDX_CFG && !rd_hi
      && !cfg_wr |=> rdata_q == {19'h0, cfg_view})
      else $error("Shared register differs by core.");

   write_answer_a: assert property (
      do_wr |=> bvalid_q && bresp_q == (
         $past(wr_ok) ? pcmb_pkg::RESP_OKAY : pcmb_pkg::RESP_SLVERR))
      else $error("Write answer missing or wrong.");

endmodule : pcmb_bank

// file: tb.sv
`timescale 1ns/10ps
module tb;
   logic          clk, rst_n;
   logic [11:0]   awaddr, araddr;
   logic [2:0]    awprot, arprot, plat_strap;
   logic          awvalid, awready, wvalid, wready, bvalid, bready;
   logic          arvalid, arready, rvalid, rready;
   logic [31:0]   wdata, rdata, stat_exp;
   logic [3:0]    wstrb;
   logic [1:0]    bresp, rresp;
   logic          tri_s, st_s, ap_s, ri_s;
   logic [127:0]  mc_addr, mc_type;
   wire  [5:0]    en;
   int            error_cnt, n_compared;

   // Design under test with both cores present.
   pcmb_bank #(.NCORES(2)) dut (.clk(clk), .rst_n(rst_n),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .plat_strap(plat_strap), .tristate_strap(tri_s),
      .self_test_strap(st_s), .apar_obs_strap(ap_s),
      .reinit_obs_strap(ri_s), .mc_addr(mc_addr), .mc_type(mc_type),
      .data_chk_en(en[0]), .resp_chk_en(en[1]), .apar_drv_en(en[2]),
      .bus_err_n_req_en(en[3]), .bus_err_n_int_en(en[4]), .reinit_drv_en(en[5]));

   // Clock of 8 ns period.
   always #4 clk = ~clk;

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // Compares one word and counts the result.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Byte address of one register word.
   function automatic logic [11:0] adr(input logic c, input logic h,
                                       input logic [7:0] idx);
      return {c, h, idx, 2'h0};
   endfunction : adr

   // Counts a hung handshake and closes the run.
   task automatic hang();
      error_cnt++;
      $display("ERROR %0t bus handshake timed out", $time);
      stop_test();
   endtask : hang

   // One write; address and data are offered together.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int i;
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s;
      wvalid <= 1'b1; bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 100) hang();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
   endtask : wr

   // One read, checked against the expected word and answer.
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int i;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 100) hang();
      rready <= 1'b0;
      chk(rdata, ed, "rdata");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
   endtask : rd

   // Straps and platform code across every code value, one reset each.
   task automatic t_straps();
      logic [2:0]  n;
      logic [31:0] pw;
      for (int k = 0; k < 8; k++) begin
         n = k[2:0];
         pw = {11'h0, n, 18'h0};
         plat_strap <= n; tri_s <= n[0]; st_s <= n[1];
         ap_s <= n[2]; ri_s <= ~n[0];
         @(posedge clk);
         rst_n <= 1'b0;
         repeat (20) @(posedge clk);
         rst_n <= 1'b1;
         repeat (2) @(posedge clk);
         stat_exp = {19'h0, ~n[0], 1'b0, n[2], n[1], n[0], 8'h00};
         chk({26'h0, en}, 32'h0, "enables after reset");
         rd(adr(0, 1, pcmb_pkg::IDX_PLATFORM), pw, 2'h0);
         rd(adr(0, 0, pcmb_pkg::IDX_PLATFORM), 32'h0, 2'h0);
         wr(adr(0, 1, pcmb_pkg::IDX_PLATFORM), 32'hFFFFFFFF, 4'hF, 2'h0);
         rd(adr(1, 1, pcmb_pkg::IDX_PLATFORM), pw, 2'h0);
         rd(adr(0, 0, pcmb_pkg::IDX_CFG), stat_exp, 2'h0);
         rd(adr(0, 1, pcmb_pkg::IDX_CFG), 32'h0, 2'h0);
      end
   endtask : t_straps

   // Walks a single one through the configuration bits.
   task automatic t_cfg_bits();
      logic [31:0] m;
      logic [31:0] e;
      for (int b = 0; b < 13; b++) begin
         m = 32'h1 << b;
         e = (m & 32'hDE) | stat_exp;
         wr(adr(0, 0, pcmb_pkg::IDX_CFG), m, 4'hF, 2'h0);
         rd(adr(0, 0, pcmb_pkg::IDX_CFG), e, 2'h0);
         chk({26'h0, en}, {26'h0, m[7:6], m[4:1]}, "enables");
      end
   endtask : t_cfg_bits

   // A shared register written through the second core's window.
   task automatic t_shared();
      wr(adr(1, 0, pcmb_pkg::IDX_CFG), 32'hFFFFFFFF, 4'hF, 2'h0);
      rd(adr(0, 0, pcmb_pkg::IDX_CFG), 32'hDE | stat_exp, 2'h0);
      chk({26'h0, en}, 32'h3F, "all enables");
      wr(adr(1, 0, pcmb_pkg::IDX_CFG), 32'h0, 4'h1, 2'h0);
      chk({26'h0, en}, 32'h0, "enables cleared");
   endtask : t_shared

   // Private copies stay apart, and byte strobes select bytes.
   task automatic t_per_core();
      wr(adr(0, 0, pcmb_pkg::IDX_FILTER), 32'h12345678, 4'hF, 2'h0);
      wr(adr(1, 0, pcmb_pkg::IDX_FILTER), 32'h0BADF00D, 4'hF, 2'h0);
      wr(adr(1, 1, pcmb_pkg::IDX_INTC), 32'hFEE00000, 4'hF, 2'h0);
      wr(adr(0, 0, pcmb_pkg::IDX_FILTER), 32'hFFFFFFFF, 4'h2, 2'h0);
      rd(adr(0, 0, pcmb_pkg::IDX_FILTER), 32'h1234FF78, 2'h0);
      rd(adr(1, 0, pcmb_pkg::IDX_FILTER), 32'h0BADF00D, 2'h0);
      rd(adr(0, 1, pcmb_pkg::IDX_INTC), 32'h0, 2'h0);
      rd(adr(1, 1, pcmb_pkg::IDX_INTC), 32'hFEE00000, 2'h0);
      wr(adr(1, 1, pcmb_pkg::IDX_MC_ADDR), 32'h0, 4'hF, 2'h0);
      rd(adr(1, 1, pcmb_pkg::IDX_MC_ADDR), mc_addr[127:96], 2'h0);
      rd(adr(0, 0, pcmb_pkg::IDX_MC_TYPE), mc_type[31:0], 2'h0);
      // The low stamp half cannot carry this early, so the upper halves
      // show only what was written into each core's own copy.
      wr(adr(1, 1, pcmb_pkg::IDX_STAMP), 32'hFFFFFFFF, 4'hF, 2'h0);
      rd(adr(1, 1, pcmb_pkg::IDX_STAMP), 32'hFFFFFFFF, 2'h0);
      rd(adr(0, 1, pcmb_pkg::IDX_STAMP), 32'h0, 2'h0);
   endtask : t_per_core

   // Unmapped places answer with an error and hold nothing.
   task automatic t_unmapped();
      wr(adr(0, 0, 8'h02), 32'hFFFFFFFF, 4'hF, pcmb_pkg::RESP_SLVERR);
      rd(adr(0, 0, 8'h02), 32'h0, pcmb_pkg::RESP_SLVERR);
   endtask : t_unmapped

   // Main sequence; every input gets a value at time zero.
   initial begin
      clk = 1'b0; rst_n = 1'b0; awaddr = '0; awprot = '0; awvalid = 1'b0;
      wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0; araddr = '0;
      arprot = '0; arvalid = 1'b0; rready = 1'b0; plat_strap = '0;
      tri_s = 1'b0; st_s = 1'b0; ap_s = 1'b0; ri_s = 1'b0;
      mc_addr = 128'hC1A2B3C4D5E6F708_0011223344556677;
      mc_type = 128'h8877665544332211_A5A55A5AC3C33C3C;
      error_cnt = 0; n_compared = 0; stat_exp = '0;
      t_straps();
      t_cfg_bits();
      t_shared();
      t_per_core();
      t_unmapped();
      stop_test();
   end
endmodule : tb
